// *** rtl/adc_ctl_pkg.sv ***
// constants and types for the converter control block
package adc_ctl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RESULT = 8'h1e;
  localparam logic [7:0] IDX_CONTROL = 8'h1f;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PIN_CONFIG = 8'h9f;
  localparam int ADDR_W = 12;
  // field positions
  localparam int CTL_CLK_LSB = 6;
  localparam int CTL_CHS_LSB = 3;
  localparam int CTL_GO_BIT = 2;
  localparam int CTL_ON_BIT = 0;
  localparam int IRQ_CONV_BIT = 6;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [2:0] PIN_CONFIG_RST = 3'h0;
  localparam logic IRQ_FLAG_RST = 1'b0;
  localparam logic IRQ_ENABLE_RST = 1'b0;
  // special event trigger mode
  localparam logic [3:0] CAPCOMP_ADC_MODE = 4'hb;
  // timing: one core period is one oscillator period
  localparam int CORE_PERIOD_NS = 8;
  localparam int RC_TAD_NS = 4000;
  localparam int DIV2_HALF = 1;
  localparam int DIV8_HALF = 4;
  localparam int DIV32_HALF = 16;
  localparam int RC_HALF = RC_TAD_NS / (2 * CORE_PERIOD_NS);
  localparam int HALF_W = 8;
  localparam int SAMPLE_HALVES = 2;
  localparam int BIT_HALVES = 2;
  localparam int SETTLE_HALVES = 1;
  localparam int CNT_W = 5;
  // reference select codes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_PIN = 2'h1;
  localparam logic [1:0] REF_NONE = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RESOLVE = 2'b11,
    ST_SETTLE = 2'b10
  } conv_state_type;
endpackage

// *** rtl/tad_if.sv ***
// link between the sequencer and the bit period generator
`timescale 1ns/1ps
interface tad_if;
  logic enable;
  logic [1:0] sel;
  logic half_tick;
  modport gen (input enable, input sel, output half_tick);
  modport user (output enable, output sel, input half_tick);
endinterface

// *** rtl/tad_gen.sv ***
// conversion bit period generator, emits a pulse every half period
`timescale 1ns/1ps
module tad_gen (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // sequencer side
  tad_if.gen tad
);
  import adc_ctl_pkg::*;

  logic [HALF_W-1:0] cnt_q, cnt_d, limit;
  logic tick_q, tick_d;

  always_comb begin
    unique case (tad.sel)
      2'h0: limit = HALF_W'(DIV2_HALF);
      2'h1: limit = HALF_W'(DIV8_HALF);
      2'h2: limit = HALF_W'(DIV32_HALF);
      default: limit = HALF_W'(RC_HALF); // RL10
    endcase
    cnt_d = '0;
    tick_d = 1'b0;
    if (tad.enable) begin
      if (cnt_q >= limit - 8'h01) begin // RL8
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (ce_in) begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tad.half_tick = tick_q & tad.enable;
endmodule

// *** rtl/adc_conversion_control.sv ***
// converter control: registers, pin configuration and conversion sequencer
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) pin config register: three bits, rest zero
// (RL2) config code sets analog pins and reference
// (RL3) completion loads result, clears go, sets flag
// (RL4) result register has no reset value
// (RL5) software waits acquisition time before start
// (RL6) software waits two bit periods after completion
// (RL7) conversion lasts nine and half bit periods
// (RL8) clock select picks 2, 8, 32 or RC
// (RL9) software keeps bit period at least 1.6us
// (RL10) RC bit period typically four microseconds
// (RL11) RC clock above 1MHz for sleep only
// (RL12) output-driven pins still convert their level
// (RL13) analog pins read zero on port read
// (RL14) power-up and start are separate writes
// (RL15) special trigger in mode 1011 starts conversion
// (RL16) trigger ignored when off, timer still clears
// (RL17) software arms flag and enables before start
// (RL18) software polls go or takes the interrupt
// (RL19) reset turns converter off, aborts conversion
// (RL20) channel select picks port A pin
// (RL21) trial code resolved msb first per period
// (RL22) clearing go aborts, result and flag kept
module adc_conversion_control (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [adc_ctl_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // capture/compare special event
  input wire logic [3:0] capcomp_mode_field_in,
  input wire logic capcomp_event_in,
  output logic timer1_clear_out,
  // analog macro
  input wire logic comparator_in,
  output logic [7:0] dac_code_out,
  output logic hold_out,
  output logic converter_on_out,
  output logic [2:0] channel_select_out,
  output logic [5:0] channel_pin_out,
  output logic [4:0] analog_pins_out,
  output logic [1:0] ref_select_out,
  // port a
  input wire logic [5:0] port_a_pin_in,
  output logic [5:0] port_a_read_out,
  // status
  output logic converter_irq_flag_out,
  output logic converter_irq_enable_out,
  output logic busy_out
);
  import adc_ctl_pkg::*;

  // decode of the pin configuration code, analog mask in RA0,RA1,RA2,RA3,RA5 order
  function automatic logic [6:0] pin_map(input logic [2:0] code);
    logic [4:0] an;
    logic [1:0] rf;
    an = 5'h1f;
    rf = REF_SUPPLY;
    unique case (code)
      3'h0, 3'h2: rf = REF_SUPPLY; // RL2
      3'h1, 3'h3: begin
        an = 5'h17;
        rf = REF_PIN;
      end
      3'h4: an = 5'h0b;
      3'h5: begin
        an = 5'h03;
        rf = REF_PIN;
      end
      default: begin
        an = 5'h00;
        rf = REF_NONE;
      end
    endcase
    return {rf, an};
  endfunction

  tad_if tad ();
  tad_gen u_tad_gen (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .tad(tad.gen)
  );

  // registers
  logic [1:0] clk_sel_q, clk_sel_d;
  logic [2:0] chs_q, chs_d;
  logic go_q, go_d;
  logic on_q, on_d;
  logic [2:0] pcfg_q, pcfg_d;
  logic flag_q, flag_d;
  logic ien_q, ien_d;
  logic [7:0] result_q, result_d;
  logic [31:0] rdata_q, rdata_d;
  logic slverr_q, slverr_d;
  logic t1clr_q, t1clr_d;
  // sequencer
  conv_state_type st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] trial_q, trial_d;
  logic [7:0] bit_q, bit_d;
  logic done_pulse;
  // synchronisers
  logic cmp_m_q, cmp_s_q;
  logic [5:0] pin_m_q, pin_s_q;

  logic [7:0] idx;
  logic addr_ok, wr_en, rd_setup;
  logic [4:0] an_mask;
  logic trig_hit;

  always_comb begin
    idx = paddr_in[9:2];
    addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in[ADDR_W-1:10] == '0) &&
              (idx == IDX_IRQ_FLAGS || idx == IDX_RESULT || idx == IDX_CONTROL ||
               idx == IDX_IRQ_ENABLES || idx == IDX_PIN_CONFIG);
    wr_en = psel_in && penable_in && pwrite_in && addr_ok;
    rd_setup = psel_in && !penable_in;
    trig_hit = capcomp_event_in && (capcomp_mode_field_in == CAPCOMP_ADC_MODE);
    {ref_select_out, an_mask} = pin_map(pcfg_q);
  end

  // apb read data and error, captured in the setup phase
  always_comb begin
    rdata_d = rdata_q;
    slverr_d = slverr_q;
    if (rd_setup) begin
      slverr_d = !addr_ok;
      rdata_d = '0;
      unique case (idx)
        IDX_IRQ_FLAGS: rdata_d[IRQ_CONV_BIT] = flag_q;
        IDX_RESULT: rdata_d[7:0] = result_q;
        IDX_CONTROL: rdata_d[7:0] = {clk_sel_q, chs_q, go_q, 1'b0, on_q};
        IDX_IRQ_ENABLES: rdata_d[IRQ_CONV_BIT] = ien_q;
        IDX_PIN_CONFIG: rdata_d[7:0] = {5'h00, pcfg_q}; // RL1
        default: rdata_d = '0;
      endcase
    end
  end

  // software registers and hardware events
  always_comb begin
    clk_sel_d = clk_sel_q;
    chs_d = chs_q;
    on_d = on_q;
    go_d = go_q;
    pcfg_d = pcfg_q;
    ien_d = ien_q;
    flag_d = flag_q;
    t1clr_d = trig_hit; // RL16
    if (wr_en && idx == IDX_CONTROL) begin
      clk_sel_d = pwdata_in[CTL_CLK_LSB +: 2]; // RL8
      chs_d = pwdata_in[CTL_CHS_LSB +: 3];
      on_d = pwdata_in[CTL_ON_BIT];
      go_d = pwdata_in[CTL_GO_BIT] && pwdata_in[CTL_ON_BIT]; // RL22
    end
    if (wr_en && idx == IDX_PIN_CONFIG) begin
      pcfg_d = pwdata_in[2:0]; // RL1
    end
    if (wr_en && idx == IDX_IRQ_ENABLES) begin
      ien_d = pwdata_in[IRQ_CONV_BIT];
    end
    if (wr_en && idx == IDX_IRQ_FLAGS) begin
      flag_d = pwdata_in[IRQ_CONV_BIT];
    end
    if (done_pulse) begin
      go_d = 1'b0; // RL3
      flag_d = 1'b1; // RL3
    end
    if (trig_hit && on_q) begin
      go_d = 1'b1; // RL15
    end
    if (!on_d) begin
      go_d = 1'b0; // RL16
    end
  end

  // result register written at completion and by a software write to it
  always_comb begin
    result_d = result_q;
    if (wr_en && idx == IDX_RESULT) begin
      result_d = pwdata_in[7:0];
    end
    if (done_pulse) begin
      result_d = trial_q; // RL3
    end
  end

  // conversion sequencer: 2 + 16 + 1 half periods
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    trial_d = trial_q;
    bit_d = bit_q;
    done_pulse = 1'b0;
    if (!go_q) begin
      st_d = ST_IDLE; // RL22
      cnt_d = '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          st_d = ST_SAMPLE;
          cnt_d = '0;
          trial_d = 8'h00;
          bit_d = 8'h80;
        end
        ST_SAMPLE: if (tad.half_tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == CNT_W'(SAMPLE_HALVES - 1)) begin // RL7
            st_d = ST_RESOLVE;
            cnt_d = '0;
            trial_d = bit_q;
          end
        end
        ST_RESOLVE: if (tad.half_tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q[0] == 1'(BIT_HALVES - 1)) begin
            trial_d = (trial_q & ~(cmp_s_q ? 8'h00 : bit_q)) | (bit_q >> 1); // RL21
            bit_d = bit_q >> 1;
            if (bit_q == 8'h01) begin
              st_d = ST_SETTLE;
              cnt_d = '0;
            end
          end
        end
        ST_SETTLE: if (tad.half_tick && cnt_q == CNT_W'(SETTLE_HALVES - 1)) begin
          done_pulse = 1'b1; // RL7
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_sel_q <= CONTROL_RST[CTL_CLK_LSB +: 2]; // RL19
      chs_q <= CONTROL_RST[CTL_CHS_LSB +: 3];
      go_q <= CONTROL_RST[CTL_GO_BIT];
      on_q <= CONTROL_RST[CTL_ON_BIT];
      pcfg_q <= PIN_CONFIG_RST;
      flag_q <= IRQ_FLAG_RST;
      ien_q <= IRQ_ENABLE_RST;
      rdata_q <= '0;
      slverr_q <= 1'b0;
      t1clr_q <= 1'b0;
      st_q <= ST_IDLE;
      cnt_q <= '0;
      trial_q <= 8'h00;
      bit_q <= 8'h00;
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
      pin_m_q <= 6'h00;
      pin_s_q <= 6'h00;
    end else if (ce_in) begin
      clk_sel_q <= clk_sel_d;
      chs_q <= chs_d;
      go_q <= go_d;
      on_q <= on_d;
      pcfg_q <= pcfg_d;
      flag_q <= flag_d;
      ien_q <= ien_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
      t1clr_q <= t1clr_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      trial_q <= trial_d;
      bit_q <= bit_d;
      cmp_m_q <= comparator_in;
      cmp_s_q <= cmp_m_q;
      pin_m_q <= port_a_pin_in;
      pin_s_q <= pin_m_q;
    end
  end

  // no reset on the result
  always_ff @(posedge core_clk_in) begin
    if (ce_in) begin
      result_q <= result_d; // RL4
    end
  end

  assign tad.enable = go_q;
  assign tad.sel = clk_sel_q;

  assign prdata_out = rdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && slverr_q;
  assign timer1_clear_out = t1clr_q; // RL15
  assign dac_code_out = trial_q;
  assign hold_out = (st_q != ST_IDLE) && (st_q != ST_SAMPLE);
  assign converter_on_out = on_q;
  assign channel_select_out = chs_q;
  // channel routed regardless of pin direction
  always_comb begin
    channel_pin_out = 6'h00;
    unique case (chs_q)
      3'h0, 3'h1, 3'h2, 3'h3: channel_pin_out = 6'h01 << chs_q; // RL20
      3'h4: channel_pin_out = 6'h20; // RL20
      default: channel_pin_out = 6'h00;
    endcase
  end
  assign analog_pins_out = an_mask; // RL12
  assign port_a_read_out = pin_s_q & ~{an_mask[4], 1'b0, an_mask[3:0]}; // RL13
  assign converter_irq_flag_out = flag_q;
  assign converter_irq_enable_out = ien_q;
  assign busy_out = go_q;
endmodule

// *** tb/adc_analog_model.sv ***
// analog side model: sample-and-hold and comparator
`timescale 1ns/1ps
module adc_analog_model (
  // clock
  input wire logic core_clk_in,
  // analog level and converter side
  input wire logic [7:0] level_in,
  input wire logic hold_in,
  input wire logic [7:0] dac_code_in,
  output logic comparator_out
);
  logic [7:0] held_q;
  // tracks the input until hold, then keeps it
  always @(posedge core_clk_in) begin
    if (!hold_in) begin
      held_q <= level_in;
    end
  end
  assign comparator_out = held_q >= dac_code_in;
endmodule

// *** tb/adc_ctl_props.sv ***
// assertions on the converter control ports
`timescale 1ns/1ps
module adc_ctl_props (
  input logic core_clk_in,
  input logic rstn_in,
  input logic psel_in,
  input logic penable_in,
  input logic pwrite_in,
  input logic [3:0] capcomp_mode_field_in,
  input logic capcomp_event_in,
  input logic timer1_clear_out,
  input logic [7:0] dac_code_out,
  input logic hold_out,
  input logic converter_on_out,
  input logic [4:0] analog_pins_out,
  input logic [1:0] ref_select_out,
  input logic [5:0] port_a_read_out,
  input logic converter_irq_flag_out,
  input logic busy_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence trig_s;
    capcomp_event_in && capcomp_mode_field_in == 4'hb;
  endsequence
  timer_clear_a: assert property (trig_s |=> timer1_clear_out)
    else $error("timer clear missing");
  trig_start_a: assert property (trig_s ##0 converter_on_out |=> busy_out)
    else $error("trigger did not start");
  trig_off_a: assert property (trig_s ##0 !converter_on_out ##0 !busy_out |=> !busy_out)
    else $error("trigger started while off");
  done_flag_a: assert property ($fell(busy_out) && !$past(psel_in && penable_in && pwrite_in) |-> converter_irq_flag_out)
    else $error("completion without flag");
  analog_read_a: assert property ((port_a_read_out[3:0] & analog_pins_out[3:0]) == 4'h0 && !(port_a_read_out[5] && analog_pins_out[4]))
    else $error("analog pin read high");
  ref_none_a: assert property (analog_pins_out == 5'h00 |-> ref_select_out == 2'h2)
    else $error("reference wrong when all digital");
  msb_first_a: assert property ($rose(hold_out) |-> ##[0:2] dac_code_out == 8'h80)
    else $error("first trial code not msb");
  off_idle_a: assert property (!converter_on_out |-> ##[0:1] !busy_out)
    else $error("busy while off");
endmodule
bind adc_conversion_control adc_ctl_props adc_ctl_props_inst (.core_clk_in, .rstn_in, .psel_in, .penable_in,
  .pwrite_in, .capcomp_mode_field_in, .capcomp_event_in, .timer1_clear_out, .dac_code_out, .hold_out,
  .converter_on_out, .analog_pins_out, .ref_select_out, .port_a_read_out, .converter_irq_flag_out, .busy_out);

// *** tb/adc_conversion_control_tb_top.sv ***
// testbench for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
  import adc_ctl_pkg::*;
  logic core_clk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, capcomp_event_in = 0, ce_in = 1;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out;
  logic [3:0] capcomp_mode_field_in = 0;
  logic [7:0] vin = 0, dac_code_out, q;
  logic [5:0] port_a_pin_in = 6'h3f, port_a_read_out, channel_pin_out;
  logic [4:0] analog_pins_out;
  logic [2:0] channel_select_out;
  logic [1:0] ref_select_out;
  logic pready_out, pslverr_out, timer1_clear_out, comparator_in, hold_out, converter_on_out, e;
  logic converter_irq_flag_out, converter_irq_enable_out, busy_out;
  int err_total = 0, checks_done = 0, cyc = 0, n;
  localparam logic [4:0] AM_T [8] = '{5'h1f, 5'h17, 5'h1f, 5'h17, 5'h0b, 5'h03, 5'h00, 5'h00};
  localparam logic [1:0] RF_T [8] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
  localparam int HT [4] = '{DIV2_HALF, DIV8_HALF, DIV32_HALF, RC_HALF};
  // the fastest select is below the minimum bit period, so only a full-scale input is judged there
  localparam logic [7:0] VT [4] = '{8'hff, 8'ha5, 8'h00, 8'h5a};
  always #4 core_clk_in = ~core_clk_in;
  adc_conversion_control adc_conversion_control_inst (.core_clk_in, .rstn_in, .ce_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .capcomp_mode_field_in, .capcomp_event_in, .timer1_clear_out, .comparator_in, .dac_code_out, .hold_out,
    .converter_on_out, .channel_select_out, .channel_pin_out, .analog_pins_out, .ref_select_out,
    .port_a_pin_in, .port_a_read_out, .converter_irq_flag_out, .converter_irq_enable_out, .busy_out);
  adc_analog_model adc_analog_model_inst (.core_clk_in, .level_in(vin), .hold_in(hold_out),
    .dac_code_in(dac_code_out), .comparator_out(comparator_in));
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] i, logic [7:0] d);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= {2'h0, i, 2'h0};
    pwdata_in <= {24'h0, d};
    @(posedge core_clk_in);
    penable_in <= 1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    q = prdata_out[7:0];
    e = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    @(posedge core_clk_in);
  endtask
  task automatic wr(logic [7:0] i, logic [7:0] d);
    apb(1, i, d);
  endtask
  task automatic rd(logic [7:0] i);
    apb(0, i, 8'h00);
  endtask
  task automatic wait_idle();
    n = 0;
    while (busy_out === 1'b1) begin
      @(posedge core_clk_in);
      n++;
    end
  endtask
  task automatic pulse(logic [3:0] m, logic b, logic c);
    capcomp_mode_field_in <= m;
    capcomp_event_in <= 1;
    @(posedge core_clk_in);
    capcomp_event_in <= 0;
    @(negedge core_clk_in);
    chk("timer clear", timer1_clear_out, c);
    chk("trigger go", busy_out, b);
    @(posedge core_clk_in);
  endtask
  task automatic t_regs();
    rd(IDX_CONTROL);
    chk("control reset", q, 0);
    rd(IDX_IRQ_FLAGS);
    chk("flags reset", q, 0);
    rd(8'h00);
    chk("unmapped", e, 1);
    wr(IDX_PIN_CONFIG, 8'hff);
    rd(IDX_PIN_CONFIG);
    chk("pin config", q, 8'h07);
    wr(IDX_IRQ_ENABLES, 8'hff);
    rd(IDX_IRQ_ENABLES);
    chk("enables", q, 8'h40);
    chk("enable out", converter_irq_enable_out, 1);
    $display("t_regs done");
  endtask
  task automatic t_pins();
    for (int c = 0; c < 8; c++) begin
      wr(IDX_PIN_CONFIG, c[7:0]);
      repeat (3) @(posedge core_clk_in);
      chk("analog mask", analog_pins_out, AM_T[c]);
      chk("reference", ref_select_out, RF_T[c]);
      chk("port read", port_a_read_out, {~AM_T[c][4], 1'b1, ~AM_T[c][3:0]});
    end
    wr(IDX_PIN_CONFIG, 8'h00);
    $display("t_pins done");
  endtask
  task automatic t_conv();
    for (int s = 0; s < 4; s++) begin
      vin <= VT[s];
      wr(IDX_CONTROL, {s[1:0], 6'h09});
      repeat (2 * HT[s]) @(posedge core_clk_in);
      chk("channel pin", channel_pin_out, 6'h02);
      chk("channel select", channel_select_out, 3'h1);
      wr(IDX_CONTROL, {s[1:0], 6'h0d});
      wait_idle();
      chk("duration", n >= 19 * HT[s] - 3 && n <= 19 * HT[s] + 4, 1);
      rd(IDX_RESULT);
      chk("result", q, VT[s]);
      chk("flag", converter_irq_flag_out, 1);
      wr(IDX_IRQ_FLAGS, 8'h00);
    end
    $display("t_conv done");
  endtask
  task automatic t_trig();
    wr(IDX_CONTROL, 8'h48);
    pulse(4'hb, 0, 1);
    wr(IDX_CONTROL, 8'h49);
    pulse(4'ha, 0, 0);
    pulse(4'hb, 1, 1);
    ce_in <= 0;
    @(posedge core_clk_in);
    q = dac_code_out;
    repeat (50) @(posedge core_clk_in);
    chk("frozen code", dac_code_out, q);
    chk("frozen busy", busy_out, 1);
    ce_in <= 1;
    wait_idle();
    chk("trigger flag", converter_irq_flag_out, 1);
    rd(IDX_RESULT);
    chk("trigger result", q, 8'h5a);
    wr(IDX_IRQ_FLAGS, 8'h00);
    $display("t_trig done");
  endtask
  task automatic t_abort();
    wr(IDX_CONTROL, 8'h49);
    vin <= 8'h33;
    wr(IDX_CONTROL, 8'h4d);
    repeat (20) @(posedge core_clk_in);
    wr(IDX_CONTROL, 8'h49);
    repeat (100) @(posedge core_clk_in);
    rd(IDX_RESULT);
    chk("kept result", q, 8'h5a);
    chk("kept flag", converter_irq_flag_out, 0);
    wr(IDX_CONTROL, 8'h4d);
    repeat (20) @(posedge core_clk_in);
    rstn_in <= 0;
    @(posedge core_clk_in);
    rstn_in <= 1;
    @(posedge core_clk_in);
    chk("reset off", converter_on_out, 0);
    chk("reset idle", busy_out, 0);
    rd(IDX_RESULT);
    chk("result after reset", q, 8'h5a);
    $display("t_abort done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk_in);
    rstn_in <= 1;
    @(posedge core_clk_in);
    t_regs();
    t_pins();
    t_conv();
    t_trig();
    t_abort();
    finish_test();
  end
endmodule
